// >>> design/ngpio_params.svh
// What this block does
// - Twelve two-way port bits form three groups of four, each group's direction set by one bit.
// - A group whose direction bit is 0 leaves its pins undriven so they act as inputs.
// - A group whose direction bit is 1 drives each pin to the level of its stored data bit.
// - A data read returns the stored value for output groups and the pin levels for input groups.
// - Reset clears all three direction bits, so every group starts as input.
// - While the third group serves the serial link its direction bit is plain storage only.
// - A pull-up enable bit of 1 turns on its group's pull-ups, but only while that group's pins are undriven.
// - Reset clears all three pull-up enable bits.
// - Data writes are accepted in input mode and kept for later output.
// - While the third group serves the serial link its data bits are plain storage only.
// - The group data registers sit at D8H, D9H and DAH in group order.
// - Direction bits sit in bits 0 to 2 of D6H, bit 0 for the first group.
// - Pull-up enable bits sit in bits 0 to 2 of D7H, bit 0 for the first group.
`ifndef NGPIO_PARAMS_SVH
`define NGPIO_PARAMS_SVH
`define NGPIO_IDX_DIR   8'hD6
`define NGPIO_IDX_PUP   8'hD7
`define NGPIO_IDX_DATA0 8'hD8
`define NGPIO_IDX_DATA1 8'hD9
`define NGPIO_IDX_DATA2 8'hDA
`define NGPIO_ADDR_W    10
`define NGPIO_DIR_RESET 3'h0
`define NGPIO_PUP_RESET 3'h0
`define NGPIO_DAT_RESET 4'h0
`define NGPIO_BAD_READ  32'h0000_0000
`endif

// >>> design/ngpio_pkg.sv
package ngpio_pkg;
    typedef enum logic [2:0] {
        NGPIO_IDLE = 3'b001,
        NGPIO_RESP = 3'b010,
        NGPIO_HOLD = 3'b100
    } ngpio_bus_t;
endpackage

// >>> design/ngpio_sync.sv
`timescale 1ns/1ps
module ngpio_sync #(
    parameter int WIDTH = 12
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end
        else if (clk_en)
        begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule

// >>> design/ngpio_top.sv
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ngpio_params.svh"
module ngpio_top
    import ngpio_pkg::*;
#(
    parameter int GROUPS = 3,
    parameter int GW     = 4
) (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic                       clk_en,
    input  wire logic [`NGPIO_ADDR_W-1:0]   avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    output logic      [1:0]                 avs_response,
    input  wire logic                       serial_select,
    input  wire logic [GROUPS*GW-1:0]       pins_in,
    output logic      [GROUPS*GW-1:0]       pins_out,
    output logic      [GROUPS*GW-1:0]       pins_oe,
    output logic      [GROUPS*GW-1:0]       pullup_on
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        ngpio_bus_t             bus;
        logic [GROUPS-1:0]      dir;
        logic [GROUPS-1:0]      pullup_enable_bit;
        logic [GROUPS*GW-1:0]   dat;
        logic [31:0]            rdata;
        logic [1:0]             resp;
    } ngpio_state_t;

    ngpio_state_t          st_reg;
    ngpio_state_t          st_next;
    logic [GROUPS*GW-1:0]  pins_sync;
    logic [GROUPS-1:0]     drive_en;
    logic [7:0]            idx;

    // word index from byte address
    function automatic logic [7:0] word_index(input logic [`NGPIO_ADDR_W-1:0] a);
        word_index = a[9:2];
    endfunction

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i >= `NGPIO_IDX_DIR) && (i <= `NGPIO_IDX_DATA2);
    endfunction

    assign idx = word_index(avs_address);

    ngpio_sync #(
        .WIDTH (GROUPS*GW)
    ) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (pins_in),
        .sync_out (pins_sync)
    );

    // ************************************************************
    // pin drive
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : gen_grp
            // serial link owns the last group's pins
            assign drive_en[g] = st_reg.dir[g] & ~(serial_select & (g == GROUPS-1));
            assign pins_oe[g*GW +: GW]   = {GW{drive_en[g]}};
            // data only reaches the pins while driving
            assign pins_out[g*GW +: GW]  = drive_en[g] ? st_reg.dat[g*GW +: GW] : '0;
            assign pullup_on[g*GW +: GW] = {GW{st_reg.pullup_enable_bit[g] & ~drive_en[g]}};
        end
    endgenerate

    // ************************************************************
    // bus and registers
    // ************************************************************
    always_comb
    begin
        logic [GROUPS*GW-1:0] view;
        view = '0;
        st_next = st_reg;
        for (int k = 0; k < GROUPS; k++)
        begin
            // stored bits in output mode or serial storage, pins otherwise
            if (st_reg.dir[k] || (serial_select && k == GROUPS-1))
                view[k*GW +: GW] = st_reg.dat[k*GW +: GW];
            else
                view[k*GW +: GW] = pins_sync[k*GW +: GW];
        end
        case (st_reg.bus)
            NGPIO_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    st_next.bus   = NGPIO_RESP;
                    st_next.rdata = `NGPIO_BAD_READ;
                    st_next.resp  = is_mapped(idx) ? 2'h0 : 2'h2;
                    if (avs_read)
                    begin
                        if (idx == `NGPIO_IDX_DIR)
                            st_next.rdata = {29'h0, st_reg.dir};
                        else if (idx == `NGPIO_IDX_PUP)
                            st_next.rdata = {29'h0, st_reg.pullup_enable_bit};
                        else if (idx == `NGPIO_IDX_DATA0)
                            st_next.rdata = {28'h0, view[3:0]};
                        else if (idx == `NGPIO_IDX_DATA1)
                            st_next.rdata = {28'h0, view[7:4]};
                        else if (idx == `NGPIO_IDX_DATA2)
                            st_next.rdata = {28'h0, view[11:8]};
                    end
                    else if (avs_byteenable[0])
                    begin
                        if (idx == `NGPIO_IDX_DIR)
                            st_next.dir = avs_writedata[2:0];
                        else if (idx == `NGPIO_IDX_PUP)
                            st_next.pullup_enable_bit = avs_writedata[2:0];
                        else if (idx == `NGPIO_IDX_DATA0)
                            st_next.dat[3:0] = avs_writedata[3:0];
                        else if (idx == `NGPIO_IDX_DATA1)
                            st_next.dat[7:4] = avs_writedata[3:0];
                        else if (idx == `NGPIO_IDX_DATA2)
                            st_next.dat[11:8] = avs_writedata[3:0];
                    end
                end
            end
            NGPIO_RESP:
                st_next.bus = NGPIO_HOLD;
            NGPIO_HOLD:
                st_next.bus = NGPIO_IDLE;
            default:
                st_next.bus = NGPIO_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg.bus   <= NGPIO_IDLE;
            st_reg.dir   <= `NGPIO_DIR_RESET;
            st_reg.pullup_enable_bit   <= `NGPIO_PUP_RESET;
            st_reg.dat   <= {GROUPS{`NGPIO_DAT_RESET}};
            st_reg.rdata <= '0;
            st_reg.resp  <= '0;
        end
        else if (clk_en)
            st_reg <= st_next;
    end

    // waitrequest drops in the cycle after the request is seen
    assign avs_waitrequest = ~(st_reg.bus == NGPIO_RESP);
    assign avs_readdata    = st_reg.rdata;
    assign avs_response    = st_reg.resp;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_dir_write;
        avs_write && avs_byteenable[0] && idx == `NGPIO_IDX_DIR && st_reg.bus == NGPIO_IDLE
            && clk_en;
    endsequence

    a_input_undriven: assert property (!st_reg.dir[0] |-> pins_oe[3:0] == 4'h0)
        else $error("input group drives pins");
    a_output_level: assert property (st_reg.dir[1] |-> pins_oe[7:4] == 4'hF
        && pins_out[7:4] == st_reg.dat[7:4])
        else $error("output group level wrong");
    a_serial_no_drive: assert property (serial_select |-> pins_oe[11:8] == 4'h0)
        else $error("serial group driven");
    a_pullup_input_only: assert property (pullup_on[3:0] != 4'h0 |->
        st_reg.pullup_enable_bit[0] && !st_reg.dir[0])
        else $error("pullup outside input mode");
    a_dir_write_lands: assert property (s_dir_write |=> st_reg.dir == $past(avs_writedata[2:0]))
        else $error("direction write lost");
    a_data_write_input: assert property (avs_write && avs_byteenable[0] && clk_en
        && idx == `NGPIO_IDX_DATA0 && st_reg.bus == NGPIO_IDLE
        |=> st_reg.dat[3:0] == $past(avs_writedata[3:0]))
        else $error("data write lost");
    a_read_output_reg: assert property (avs_read && clk_en && st_reg.bus == NGPIO_IDLE
        && idx == `NGPIO_IDX_DATA1 && st_reg.dir[1]
        |=> avs_readdata == {28'h0, $past(st_reg.dat[7:4])})
        else $error("output read mismatch");
    a_pup_readback: assert property (avs_read && clk_en && st_reg.bus == NGPIO_IDLE
        && idx == `NGPIO_IDX_PUP |=> avs_readdata[31:3] == 29'h0)
        else $error("pullup read upper bits set");
    a_sync_delay: assert property ($past(clk_en) && $past(clk_en, 2) && $past(resetn)
        && $past(resetn, 2) |-> pins_sync == $past(pins_in, 2))
        else $error("sync delay wrong");

    // ************************************************************
    // bus handshake checks
    // ************************************************************
    sequence s_taken;
        (avs_read || avs_write) && clk_en && st_reg.bus == NGPIO_IDLE;
    endsequence

    sequence s_answer;
        !avs_waitrequest;
    endsequence

    a_bus_answer: assert property (s_taken |=> s_answer)
        else $error("request not answered");

    a_wait_one_cycle: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
        else $error("waitrequest low too long");

    a_hold_refuses: assert property (st_reg.bus == NGPIO_HOLD |-> avs_waitrequest)
        else $error("answer during hold");

    a_bus_onehot: assert property ($onehot(st_reg.bus))
        else $error("bus state not one-hot");

    a_mapped_resp: assert property (s_taken ##0 is_mapped(idx) |=> avs_response == 2'h0)
        else $error("mapped response wrong");

    a_unmapped_resp: assert property (s_taken ##0 !is_mapped(idx) |=> avs_response == 2'h2)
        else $error("unmapped response wrong");

    a_unmapped_zero: assert property (s_taken ##0 avs_read && !is_mapped(idx)
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");

    a_unmapped_ignored: assert property (s_taken ##0 avs_write && !is_mapped(idx)
        |=> st_reg.dir == $past(st_reg.dir) && st_reg.pullup_enable_bit == $past(st_reg.pullup_enable_bit)
        && st_reg.dat == $past(st_reg.dat))
        else $error("unmapped write landed");

    a_readdata_stands: assert property (!(avs_read || avs_write) && st_reg.bus == NGPIO_IDLE
        |=> $stable(avs_readdata) && $stable(avs_response))
        else $error("read data moved while idle");

    a_freeze_state: assert property (!clk_en |=> $stable(st_reg))
        else $error("state moved while frozen");

    // ************************************************************
    // register checks
    // ************************************************************
    a_pup_write_lands: assert property (s_taken ##0 avs_write && avs_byteenable[0]
        && idx == `NGPIO_IDX_PUP |=> st_reg.pullup_enable_bit == $past(avs_writedata[2:0]))
        else $error("pullup write lost");

    a_data2_write_lands: assert property (s_taken ##0 avs_write && avs_byteenable[0]
        && idx == `NGPIO_IDX_DATA2 |=> st_reg.dat[11:8] == $past(avs_writedata[3:0]))
        else $error("group2 data write lost");

    a_dir_readback: assert property (s_taken ##0 avs_read && idx == `NGPIO_IDX_DIR
        |=> avs_readdata == {29'h0, $past(st_reg.dir)})
        else $error("direction read mismatch");

    a_read_input_pins: assert property (s_taken ##0 avs_read && idx == `NGPIO_IDX_DATA0
        && !st_reg.dir[0] |=> avs_readdata == {28'h0, $past(pins_sync[3:0])})
        else $error("input read mismatch");

    a_read_serial_store: assert property (s_taken ##0 avs_read && idx == `NGPIO_IDX_DATA2
        && serial_select |=> avs_readdata == {28'h0, $past(st_reg.dat[11:8])})
        else $error("serial storage read mismatch");

    // ************************************************************
    // pin checks
    // ************************************************************
    a_input_undriven_g1: assert property (!st_reg.dir[1] |-> pins_oe[7:4] == 4'h0)
        else $error("input group1 drives pins");

    a_input_undriven_g2: assert property (!st_reg.dir[2] |-> pins_oe[11:8] == 4'h0)
        else $error("input group2 drives pins");

    a_output_level_g0: assert property (st_reg.dir[0] |-> pins_oe[3:0] == 4'hF
        && pins_out[3:0] == st_reg.dat[3:0])
        else $error("group0 output level wrong");

    a_output_level_g2: assert property (st_reg.dir[2] && !serial_select
        |-> pins_oe[11:8] == 4'hF && pins_out[11:8] == st_reg.dat[11:8])
        else $error("group2 output level wrong");

    a_serial_no_out: assert property (serial_select |-> pins_out[11:8] == 4'h0)
        else $error("serial group data on pins");

    a_pullup_on_g1: assert property (st_reg.pullup_enable_bit[1] && !st_reg.dir[1]
        |-> pullup_on[7:4] == 4'hF)
        else $error("group1 pullup missing");

    a_pullup_off_g1: assert property (!st_reg.pullup_enable_bit[1] |-> pullup_on[7:4] == 4'h0)
        else $error("group1 pullup without enable");
endmodule

// >>> dv/ngpio_pins.sv
`timescale 1ns/1ps
// ************************************************
// keys and switches on the twelve pins
// ************************************************
module ngpio_pins (
    input  wire logic        ref_clk,
    input  wire logic [11:0] pins_out,
    input  wire logic [11:0] pins_oe,
    input  wire logic [11:0] pullup_on,
    input  wire logic [11:0] key_en,
    input  wire logic [11:0] key_lvl,
    output logic      [11:0] pins_in
);
    logic [11:0] float_reg = 12'h000;
    // undriven, unpulled pins with no key enabled toggle every cycle
    always @(posedge ref_clk)
        float_reg <= ~float_reg;
    always_comb
        pins_in = (pins_oe & pins_out) | (~pins_oe & key_en & key_lvl)
                | (~pins_oe & ~key_en & pullup_on)
                | (~pins_oe & ~key_en & ~pullup_on & float_reg);
endmodule

// >>> dv/test_nibble_gpio_with_pullups.sv
`timescale 1ns/1ps
// ************************************************
// bench for the nibble port block
// ************************************************
module test_nibble_gpio_with_pullups;
    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] rd; logic [1:0] rsp;} ngpio_row_t;
    logic        ref_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic        serial_select = 1'b0, avs_waitrequest;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0]  avs_response, r;
    logic [11:0] pins_in, pins_out, pins_oe, pullup_on;
    logic [11:0] key_en = 12'h000, key_lvl = 12'h000;
    int          mismatches = 0, samples_checked = 0;
    ngpio_row_t  rows [6] = '{'{8'hD6, 32'h5, 32'h5, 2'h0}, '{8'hD7, 32'h6, 32'h6, 2'h0},
        '{8'hD8, 32'hA, 32'hA, 2'h0}, '{8'hD9, 32'h3, 32'hF, 2'h0},
        '{8'hDA, 32'hC, 32'hC, 2'h0}, '{8'h10, 32'h7, 32'h0, 2'h2}};
    ngpio_top uut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .serial_select(serial_select), .pins_in(pins_in), .pins_out(pins_out),
        .pins_oe(pins_oe), .pullup_on(pullup_on));
    ngpio_pins keys (.ref_clk(ref_clk), .pins_out(pins_out), .pins_oe(pins_oe),
        .pullup_on(pullup_on), .key_en(key_en), .key_lvl(key_lvl), .pins_in(pins_in));
    // ************************************************
    // tasks
    // ************************************************
    task automatic end_of_test();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic void chk(string nm, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endfunction
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // ************************************************
    // clock, watchdog, sequence
    // ************************************************
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    initial
    begin
        #1000000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        chk("pins_oe", 0, pins_oe);
        resetn <= 1'b1;
        bus(0, 8'hD6, 0); chk("dir", 0, q);
        bus(0, 8'hD7, 0); chk("pup", 0, q);
        foreach (rows[i])
        begin
            bus(1, rows[i].idx, rows[i].wd);
            bus(0, rows[i].idx, 0);
            chk("readdata", rows[i].rd, q);
            chk("response", rows[i].rsp, r);
        end
        @(negedge ref_clk);
        chk("pins_oe", 12'hF0F, pins_oe);
        chk("pins_out", 12'hC0A, pins_out);
        chk("pullup_on", 12'h0F0, pullup_on);
        bus(1, 8'hD6, 7); bus(0, 8'hD9, 0); chk("data1", 3, q);
        @(negedge ref_clk);
        chk("pins_out", 12'hC3A, pins_out);
        key_en <= 12'hFFF;
        key_lvl <= 12'h5A3;
        bus(1, 8'hD6, 0);
        bus(0, 8'hD8, 0); chk("in0", 3, q);
        bus(0, 8'hD9, 0); chk("in1", 12'hA, q);
        bus(0, 8'hDA, 0); chk("in2", 5, q);
        chk("pullup_on", 12'hFF0, pullup_on);
        serial_select <= 1'b1;
        bus(1, 8'hD6, 4); chk("pins_oe", 0, pins_oe);
        bus(0, 8'hD6, 0); chk("dir", 4, q);
        bus(1, 8'hDA, 9); bus(0, 8'hDA, 0); chk("data2", 9, q);
        chk("pins_out", 0, pins_out);
        resetn <= 1'b0;
        @(negedge ref_clk);
        chk("pins_oe", 0, pins_oe);
        chk("pullup_on", 0, pullup_on);
        @(posedge ref_clk);
        resetn <= 1'b1;
        serial_select <= 1'b0;
        bus(0, 8'hD6, 0); chk("dir", 0, q);
        bus(0, 8'hD7, 0); chk("pup", 0, q);
        end_of_test();
    end
endmodule
